// ### core/mppi_consts.svh
// Constants for the masked pin pattern interrupt unit.
`ifndef MPPI_CONSTS_SVH
`define MPPI_CONSTS_SVH

// -----------------------------------------------------------------------
// Pattern width and reset values
// -----------------------------------------------------------------------
`define MPPI_PORT_W     8
`define MPPI_MASK_RST   8'h00
`define MPPI_CMP_RST    8'h00

`endif

// ### core/mppi_pkg.sv
// Types shared by the masked pin pattern interrupt unit.
package mppi_pkg;

  // -----------------------------------------------------------------------
  // Arming request carried from the sequencer
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cmp;
    logic [7:0] mask;
  } mppi_pattern_t;

  typedef enum logic [1:0] {
    MPPI_IDLE    = 2'b00,
    MPPI_ARMED   = 2'b01,
    MPPI_HANDLER = 2'b10
  } mppi_state_t;

endpackage : mppi_pkg

// ### core/mppi_match.sv
// Masked compare of the input port against the held pattern.
`timescale 1ns/100ps
`include "mppi_consts.svh"

module mppi_match #(
  parameter int W = `MPPI_PORT_W
) (
  input  wire logic [W-1:0] i_port,
  input  wire logic [W-1:0] i_cmp,
  input  wire logic [W-1:0] i_mask,
  output logic              o_match
);

  // -----------------------------------------------------------------------
  // Operand build and compare
  // -----------------------------------------------------------------------
  // Masked inputs keep their own bit position, the rest are forced to zero.
  logic [W-1:0] operand;
  assign operand = i_port & i_mask;
  // A zero mask never matches, so the unit is disabled by it.
  assign o_match = (i_mask != '0) && (operand == (i_cmp & i_mask));

endmodule : mppi_match

// ### core/mppi_top.sv
// Polled pattern-match interrupt unit for the program sequencer.
`timescale 1ns/100ps
`include "mppi_consts.svh"

module mppi_top #(
  parameter int W = `MPPI_PORT_W
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic [W-1:0]          i_port,
  input  wire logic                  i_arm,
  input  wire mppi_pkg::mppi_pattern_t i_pattern,
  input  wire logic                  i_check,
  input  wire logic                  i_in_delay,
  input  wire logic                  i_ret,
  output logic                       o_call,
  output logic                       o_abort_delay,
  output logic                       o_armed,
  output logic                       o_in_handler,
  output logic                       o_pending
);

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  mppi_pkg::mppi_state_t   state_q;
  mppi_pkg::mppi_state_t   state_d;
  mppi_pkg::mppi_pattern_t pat_q;
  mppi_pkg::mppi_pattern_t pend_q;
  logic                    pend_v_q;
  logic                    match;
  logic                    poll;
  logic                    take;

  mppi_match #(
    .W (W)
  ) u_match (
    .i_port  (i_port),
    .i_cmp   (pat_q.cmp),
    .i_mask  (pat_q.mask),
    .o_match (match)
  );

  // -----------------------------------------------------------------------
  // Polling and call
  // -----------------------------------------------------------------------
  // Checks come at line and note boundaries, and on every cycle of a delay.
  assign poll = i_check | i_in_delay;
  // The call is combinational so the sequencer can branch in the same cycle.
  assign take = (state_q == mppi_pkg::MPPI_ARMED) && poll && match;
  assign o_call = take;
  // Remaining delay time is thrown away when a delay is interrupted.
  assign o_abort_delay = take && i_in_delay;
  assign o_armed = (state_q == mppi_pkg::MPPI_ARMED);
  assign o_in_handler = (state_q == mppi_pkg::MPPI_HANDLER);
  assign o_pending = pend_v_q;

  // Next state of the arming sequence.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      mppi_pkg::MPPI_IDLE:
      begin
        if (i_arm)
          state_d = mppi_pkg::MPPI_ARMED;
      end
      mppi_pkg::MPPI_ARMED:
      begin
        if (take)
          state_d = mppi_pkg::MPPI_HANDLER;
      end
      mppi_pkg::MPPI_HANDLER:
      begin
        // Return re-arms only if a request was made inside the handler.
        if (i_ret)
          state_d = (pend_v_q || i_arm) ? mppi_pkg::MPPI_ARMED
                                        : mppi_pkg::MPPI_IDLE;
      end
      default: state_d = mppi_pkg::MPPI_IDLE;
    endcase
  end

  // State register, disarmed at reset.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      state_q <= mppi_pkg::MPPI_IDLE;
    else
      state_q <= state_d;
  end

  // Active pattern; a request in the handler waits for the return.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pat_q.cmp  <= `MPPI_CMP_RST;
      pat_q.mask <= `MPPI_MASK_RST;
    end
    else if (state_q == mppi_pkg::MPPI_HANDLER)
    begin
      if (i_ret && i_arm)
        pat_q <= i_pattern;
      else if (i_ret && pend_v_q)
        pat_q <= pend_q;
    end
    else if (i_arm)
      pat_q <= i_pattern;
  end

  // Pending request held while the handler runs; a later one replaces it.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pend_v_q <= 1'b0;
      pend_q   <= '0;
    end
    else if (state_q == mppi_pkg::MPPI_HANDLER && !i_ret && i_arm)
    begin
      pend_v_q <= 1'b1;
      pend_q   <= i_pattern;
    end
    else if (i_ret)
      pend_v_q <= 1'b0;
  end

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  // The checks look at ports and the held and pending patterns, not at the internal
  // poll and match nets, so that a slip in those nets is caught here.
  a_call_needs_arm: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_call |-> o_armed && (i_check || i_in_delay))
    else $error("call without armed check");

  a_take_disarms: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_call |=> o_in_handler && !o_armed)
    else $error("call did not disarm");

  // Nothing but a request or a return may bring the unit back to armed.
  a_disarm_holds: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !o_armed && !i_arm && !(o_in_handler && i_ret) |=> !o_armed)
    else $error("armed without request");

  a_zero_mask_quiet: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (pat_q.mask == 8'h00) |-> !o_call)
    else $error("call with zero mask");

  a_masked_compare: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_call |-> ((i_port ^ pat_q.cmp) & pat_q.mask) == 8'h00)
    else $error("call on unmatched port");

  a_arm_in_handler: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_in_handler && i_arm && !i_ret |=> o_in_handler && o_pending)
    else $error("handler arming not held");

  // A request in the return cycle itself outranks the one held pending.
  a_ret_rearms: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_in_handler && i_ret && o_pending && !i_arm |=>
      o_armed && pat_q == $past(pend_q))
    else $error("return did not apply pending");

  a_ret_same_arm: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_in_handler && i_ret && i_arm |=>
      o_armed && pat_q == $past(i_pattern))
    else $error("return did not apply request");

  a_pend_clears: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_ret |=> !o_pending)
    else $error("pending kept after return");

  a_ret_no_arm: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_in_handler && i_ret && !o_pending && !i_arm |=> !o_armed)
    else $error("rearmed without request");

  // A request in the very cycle of a call loses to the call.
  a_arm_loads: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_arm && !o_in_handler && !o_call |=>
      o_armed && pat_q == $past(i_pattern))
    else $error("arming did not load pattern");

  a_abort_delay: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_call && i_in_delay |-> o_abort_delay)
    else $error("delay not aborted");

  a_abort_only_call: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_abort_delay |-> o_call && i_in_delay)
    else $error("delay aborted without call");

  a_reset_idle: assert property (
    @(posedge i_clk)
    i_rst |=> !o_armed && !o_in_handler && !o_pending &&
      pat_q.mask == 8'h00)
    else $error("reset state wrong");

  // -----------------------------------------------------------------------
  // Coverage of the main scenarios
  // -----------------------------------------------------------------------
  c_call_line: cover property (@(posedge i_clk) disable iff (i_rst)
    o_call && i_check);
  c_call_delay: cover property (@(posedge i_clk) disable iff (i_rst)
    o_call && i_in_delay);
  c_second_call: cover property (@(posedge i_clk) disable iff (i_rst)
    o_in_handler && i_ret && o_pending ##[1:4] o_call);
  c_arm_pending: cover property (@(posedge i_clk) disable iff (i_rst)
    o_in_handler && i_arm && !i_ret);
  c_zero_mask_poll: cover property (@(posedge i_clk) disable iff (i_rst)
    o_armed && pat_q.mask == 8'h00 && (i_check || i_in_delay));

endmodule : mppi_top

// ### sim/mppi_seq_model.sv
// Behavioural model of the program sequencer facing the unit.
`timescale 1ns/100ps
module mppi_seq_model #(
  parameter int HLEN = 12
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_call,
  input  wire logic i_run_delay,
  output logic      o_check = 1'b0,
  output logic      o_in_delay = 1'b0,
  output logic      o_ret = 1'b0
);
  // ---------------------------------------------------------------
  // Line pacing, delay level and handler return
  // ---------------------------------------------------------------
  logic [1:0] tick_q = 2'h0;
  logic [4:0] hcnt_q = 5'h00;
  logic       hnd_q  = 1'b0;

  // Lines end every third cycle; a call holds a delay off until the handler returns.
  always @(posedge i_clk)
  begin
    tick_q     <= (tick_q == 2'h2) ? 2'h0 : tick_q + 2'h1;
    o_check    <= !i_rst && tick_q == 2'h2 && !i_call;
    o_in_delay <= !i_rst && i_run_delay && !hnd_q && !i_call;
    o_ret      <= !i_rst && hnd_q && hcnt_q == 5'h00 && !i_call;
    if (i_rst)
      hnd_q <= 1'b0;
    else if (i_call)
    begin
      hnd_q  <= 1'b1;
      hcnt_q <= 5'(HLEN);
    end
    else if (hcnt_q != 5'h00)
      hcnt_q <= hcnt_q - 5'h01;
    else
      hnd_q <= 1'b0;
  end
endmodule : mppi_seq_model

// ### sim/mppi_top_test.sv
// Self-checking bench for the masked pin pattern interrupt unit.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  err_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module mppi_top_test;
  logic i_clk = 0, i_rst = 1, i_arm = 0, run_d = 0, e;
  logic i_check, i_in_delay, i_ret, o_call, o_abort_delay;
  logic o_armed, o_in_handler, o_pending;
  logic [7:0] i_port = 8'h00, m, c;
  mppi_pkg::mppi_pattern_t i_pattern = '0;
  int err_count = 0, checks_done = 0, cyc = 0, seed = 36, k;
  logic q[$];

  // -----------------------------------------------------------------
  // Clock, design and sequencer model
  // -----------------------------------------------------------------
  always #25 i_clk = ~i_clk;
  mppi_top i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_port(i_port),
    .i_arm(i_arm), .i_pattern(i_pattern), .i_check(i_check),
    .i_in_delay(i_in_delay), .i_ret(i_ret), .o_call(o_call),
    .o_abort_delay(o_abort_delay), .o_armed(o_armed),
    .o_in_handler(o_in_handler), .o_pending(o_pending));
  mppi_seq_model i_seq (.i_clk(i_clk), .i_rst(i_rst), .i_call(o_call),
    .i_run_delay(run_d), .o_check(i_check), .o_in_delay(i_in_delay),
    .o_ret(i_ret));

  task end_of_test;
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task arm(input logic [7:0] cv, input logic [7:0] mv);
    @(posedge i_clk);
    i_arm <= 1'b1;
    i_pattern <= '{cmp: cv, mask: mv};
    @(posedge i_clk);
    i_arm <= 1'b0;
  endtask : arm

  task wait_hnd(input logic v);
    int n;
    n = 0;
    do
    begin
      @(negedge i_clk);
      n++;
    end
    while (o_in_handler !== v && n < 60);
    `CHK("in_handler", v, o_in_handler)
  endtask : wait_hnd

  // Every call takes the oldest note; a call with none noted is wrong.
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      err_count++;
      end_of_test;
    end
    if (!i_rst && o_call === 1'b1)
      if (q.size() == 0) `CHK("call", 1'b0, o_call)
      else
      begin
        e = q.pop_front();
        `CHK("abort", e, o_abort_delay)
      end
  end

  // A zero mask first, then arm, match, re-arm in the handler, return.
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    `CHK("armed", 1'b0, o_armed)
    `CHK("pending", 1'b0, o_pending)
    run_d <= 1'b1;
    arm(8'($random(seed)), 8'h00);
    repeat (20) @(posedge i_clk) i_port <= 8'($random(seed));
    for (k = 0; k < 24; k++)
    begin
      m = 8'($random(seed)) | (8'h01 << k[2:0]);
      c = 8'($random(seed)) & m;
      @(posedge i_clk);
      run_d <= k[0];
      i_port <= (c ^ (m & -m)) | (~m & 8'($random(seed)));
      arm(c, m);
      repeat (6) @(posedge i_clk);
      q.push_back(k[0]);
      i_port <= c | (~m & 8'($random(seed)));
      wait_hnd(1'b1);
      run_d <= 1'b0;
      if (k[1])
      begin
        if (k[2]) c = ~c & m;
        arm(c, m);
        @(negedge i_clk);
        `CHK("pending", 1'b1, o_pending)
        `CHK("armed", 1'b0, o_armed)
        @(posedge i_clk);
        i_port <= c;
        q.push_back(1'b0);
        wait_hnd(1'b0);
        wait_hnd(1'b1);
      end
      wait_hnd(1'b0);
      `CHK("armed", 1'b0, o_armed)
      repeat (8) @(posedge i_clk);
    end
    // A reset inside the handler, with a request pending, clears it all.
    @(posedge i_clk);
    i_port <= 8'h80;
    q.push_back(1'b0);
    arm(8'h80, 8'h80);
    wait_hnd(1'b1);
    arm(8'h80, 8'h80);
    @(negedge i_clk);
    `CHK("pending", 1'b1, o_pending)
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    `CHK("in_handler", 1'b0, o_in_handler)
    `CHK("armed", 1'b0, o_armed)
    `CHK("pending", 1'b0, o_pending)
    `CHK("queue", 0, q.size())
    end_of_test;
  end
endmodule : mppi_top_test
